//--- bench/shbp_host_model.sv
// Purpose: master CPU model driving the host bus of the port
// Assumes: the bench issues one access at a time
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module shbp_host_model
    import shbp_pkg::*;
(
    input wire logic ref_clk_i,
    output var shbp_hbus_t hbus_o,
    input wire logic [7:0] host_data_i,
    input wire logic host_data_oe_i,
    input wire logic host_access_irq_i
);
    // ----------------------------------------------------------------
    // idle bus
    // ----------------------------------------------------------------
    // select and both strobes start released
    initial begin
        hbus_o = {3'b111, 7'h00, 8'h5A};
    end

    // ----------------------------------------------------------------
    // one access
    // ----------------------------------------------------------------
    // held over the taken edge and the answer edge, so one access only
    task automatic access(input logic sel, input logic rd, input logic [6:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic oe, output logic irq);
        @(posedge ref_clk_i);
        #10;
        hbus_o.cs_n = ~sel;
        hbus_o.rd_n = ~rd;
        hbus_o.wr_n = rd; // never both strobes
        hbus_o.addr = a;
        hbus_o.data = rd ? ~hbus_o.data : d;
        // the answer and the irq pulse stand after the taking edge; look once settled
        @(posedge ref_clk_i);
        #10;
        q = host_data_i;
        oe = host_data_oe_i;
        irq = host_access_irq_i;
        @(posedge ref_clk_i);
        #10;
        hbus_o.cs_n = 1'b1;
        hbus_o.rd_n = 1'b1;
        hbus_o.wr_n = 1'b1;
        // a released line does not keep its value
        hbus_o.data = ~hbus_o.data;
    endtask
endmodule
`default_nettype wire

//--- bench/slave_host_bus_port_tb.sv
// Purpose: self-checking bench of the slave host bus port
// Assumes: host bus model and local bus driver act one at a time
// Notes: pins resolve from enables; outside levels come from the bench
`timescale 1ns/1ps
`default_nettype none
`include "shbp_defs.svh"
module slave_host_bus_port_tb
    import shbp_pkg::*;
;
    typedef struct packed {
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
        logic irq;
    } shbp_row_t;

    // ----------------------------------------------------------------
    // host access table
    // ----------------------------------------------------------------
    localparam shbp_row_t ROWS [13] = '{
        '{1'b0, 7'h00, 8'h5A, 8'h00, 1'b0}, '{1'b0, 7'h3F, 8'hC3, 8'h00, 1'b0},
        '{1'b1, 7'h00, 8'h00, 8'h5A, 1'b0}, '{1'b1, 7'h3F, 8'h00, 8'hC3, 1'b0},
        '{1'b0, 7'h61, 8'hF0, 8'h00, 1'b0}, '{1'b0, 7'h60, 8'hA5, 8'h00, 1'b0},
        '{1'b1, 7'h60, 8'h00, 8'hAC, 1'b0}, '{1'b1, 7'h61, 8'h00, 8'hF0, 1'b0},
        '{1'b1, 7'h40, 8'h00, 8'h00, 1'b0}, '{1'b0, 7'h62, 8'hFF, 8'h00, 1'b0},
        '{1'b1, 7'h62, 8'h00, 8'h2B, 1'b0}, '{1'b0, 7'h78, 8'h77, 8'h00, 1'b1},
        '{1'b1, 7'h78, 8'h00, 8'h00, 1'b1}};

    logic ref_clk_i;
    logic rstn_i;
    shbp_hbus_t hbus;
    shbp_lbus_t lbus;
    logic [7:0] host_data_o;
    logic host_data_oe_o;
    logic irq;
    logic [7:0] loc_rdata_o;
    logic [11:0] rom_addr_o;
    logic [7:0] ssp_o, ssp_oe, ssp_ext, ssp_pin;
    logic [5:0] shp_o, shp_oe, shp_ext, shp_pin;
    logic cts_o, cts_oe_o, cts_ext, cts_pin;
    logic [7:0] q;
    logic oe, irq_seen;
    int num_errors = 0;
    int checked = 0;

    // ----------------------------------------------------------------
    // pins and rom
    // ----------------------------------------------------------------
    // a pin shows the device where it drives, the outside level elsewhere
    assign ssp_pin = (ssp_oe & ssp_o) | (~ssp_oe & ssp_ext);
    assign shp_pin = (shp_oe & shp_o) | (~shp_oe & shp_ext);
    assign cts_pin = cts_oe_o ? cts_o : cts_ext;

    function automatic logic [7:0] rom_byte(input logic [11:0] a);
        // both ends of the store give distinct bytes
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction

    shbp_port uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .hbus_i(hbus), .host_data_o(host_data_o),
        .host_data_oe_o(host_data_oe_o), .host_access_irq_o(irq), .lbus_i(lbus),
        .loc_rdata_o(loc_rdata_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_byte(rom_addr_o)),
        .system_side_port_i(ssp_pin), .system_side_port_o(ssp_o), .system_side_port_oe_o(ssp_oe),
        .shared_port_i(shp_pin), .shared_port_o(shp_o), .shared_port_oe_o(shp_oe),
        .cts_i(cts_pin), .cts_o(cts_o), .cts_oe_o(cts_oe_o));

    shbp_host_model host (.ref_clk_i(ref_clk_i), .hbus_o(hbus), .host_data_i(host_data_o),
        .host_data_oe_i(host_data_oe_o), .host_access_irq_i(irq));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle local access, read data looked at once settled after the taking edge
    task automatic lcyc(input logic rd, input logic [12:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #10;
        lbus = {rd, ~rd, a, d};
        @(posedge ref_clk_i);
        #10;
        lbus = '0;
        q = loc_rdata_o;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        num_errors++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rstn_i = 1'b0;
        lbus = '0;
        ssp_ext = 8'h3C;
        shp_ext = 6'h2B;
        cts_ext = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #10;
        check({7'h00, host_data_oe_o}, 8'h00);
        check(ssp_oe, 8'h00);
        rstn_i = 1'b1;
        foreach (ROWS[i]) begin
            host.access(1'b1, ROWS[i].rd, ROWS[i].addr, ROWS[i].wdata, q, oe, irq_seen);
            if (ROWS[i].rd) begin
                check(q, ROWS[i].exp);
                check({7'h00, oe}, 8'h01);
            end
            check({7'h00, irq_seen}, {7'h00, ROWS[i].irq});
        end
        check(ssp_oe, 8'hF0);
        check(ssp_o & ssp_oe, 8'hA0);
        // deselected accesses must leave memory and data pins alone
        host.access(1'b0, 1'b0, 7'h00, 8'hFF, q, oe, irq_seen);
        check({7'h00, oe}, 8'h00);
        host.access(1'b0, 1'b1, 7'h00, 8'h00, q, oe, irq_seen);
        check({7'h00, oe}, 8'h00);
        host.access(1'b1, 1'b1, 7'h00, 8'h00, q, oe, irq_seen);
        check(q, 8'h5A);
        // shared memory and registers seen from both buses
        lcyc(1'b1, `SHBP_LOC_DP_BASE, 8'h00);
        check(q, 8'h5A);
        lcyc(1'b0, `SHBP_LOC_DP_BASE + 13'h0005, 8'h3E);
        host.access(1'b1, 1'b1, 7'h05, 8'h00, q, oe, irq_seen);
        check(q, 8'h3E);
        lcyc(1'b1, `SHBP_LOC_MODE0, 8'h00);
        check(q, 8'h77);
        lcyc(1'b0, `SHBP_LOC_IPCE0, 8'h81);
        lcyc(1'b1, `SHBP_LOC_IPCE0, 8'h00);
        check(q, 8'h81);
        host.access(1'b1, 1'b1, 7'h78, 8'h00, q, oe, irq_seen);
        check(q, 8'h81);
        check({7'h00, irq_seen}, 8'h01);
        host.access(1'b1, 1'b1, 7'h78, 8'h00, q, oe, irq_seen);
        check(q, 8'h00);
        // shared port and its extra bit, driven locally
        lcyc(1'b0, `SHBP_LOC_SHP_DIR, 8'h7F);
        lcyc(1'b0, `SHBP_LOC_SHP_DATA, 8'h55);
        check({2'b00, shp_oe}, 8'h3F);
        check({2'b00, shp_o}, 8'h15);
        check({6'h00, cts_oe_o, cts_o}, 8'h03);
        host.access(1'b1, 1'b1, 7'h62, 8'h00, q, oe, irq_seen);
        check(q, 8'h15);
        lcyc(1'b1, `SHBP_LOC_SHP_DATA, 8'h00);
        check(q & 8'h7F, 8'h55);
        // local writes cannot reach the system-side port
        lcyc(1'b0, 13'h0060, 8'h00);
        lcyc(1'b0, 13'h0061, 8'h00);
        check(ssp_oe, 8'hF0);
        // program store at the top of the local space
        lcyc(1'b1, `SHBP_LOC_ROM_BASE, 8'h00);
        check(q, rom_byte(12'h000));
        lcyc(1'b1, 13'h1FFF, 8'h00);
        check(q, rom_byte(12'hFFF));
        // second reset in mid-run, held for the full minimum time
        @(posedge ref_clk_i);
        #10;
        rstn_i = 1'b0;
        repeat (`SHBP_RST_MIN_CYC + 1) @(posedge ref_clk_i);
        #10;
        rstn_i = 1'b1;
        check(ssp_oe, 8'h00);
        check({2'b00, shp_oe}, 8'h00);
        host.access(1'b1, 1'b1, 7'h61, 8'h00, q, oe, irq_seen);
        check(q, 8'h00);
        // back to inputs: the extra bit now shows its outside level
        lcyc(1'b1, `SHBP_LOC_SHP_DATA, 8'h00);
        check(q, {1'b0, cts_ext, shp_ext});
        print_verdict();
    end
endmodule
`default_nettype wire

//--- design/shbp_defs.svh
// Purpose: address map, reset values and timing counts of the slave host bus port
// Assumes: included by its bare name from the design files
// Notes: definitions only
`ifndef SHBP_DEFS_SVH
`define SHBP_DEFS_SVH

// ----------------------------------------------------------------
// system bus map (7-bit address)
// ----------------------------------------------------------------
`define SHBP_SYS_SSP_DATA 7'h60
`define SHBP_SYS_SSP_DIR 7'h61
`define SHBP_SYS_SHP_IN 7'h62
`define SHBP_SYS_IPC0 7'h78

// ----------------------------------------------------------------
// local bus map (13-bit address)
// ----------------------------------------------------------------
`define SHBP_LOC_DP_BASE 13'h0280
`define SHBP_LOC_DP_LAST 13'h02BF
`define SHBP_LOC_SHP_DATA 13'h00E0
`define SHBP_LOC_SHP_DIR 13'h00E1
`define SHBP_LOC_MODE0 13'h00F0
`define SHBP_LOC_IPCE0 13'h00F4
`define SHBP_LOC_ROM_BASE 13'h1000

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define SHBP_DIR_RST 8'h00
`define SHBP_OUT_RST 8'h00
`define SHBP_REG_RST 8'h00
`define SHBP_IDLE_DATA 8'h00
`define SHBP_CLK_NS 100
`define SHBP_RST_MIN_NS 2000
`define SHBP_RST_MIN_CYC ((`SHBP_RST_MIN_NS + `SHBP_CLK_NS - 1) / `SHBP_CLK_NS)

`endif

//--- design/shbp_dpram.sv
// Purpose: 64-byte RAM with independent system and local ports
// Assumes: both ports in the same clock
// Notes: same-address writes in one cycle leave the system value
`timescale 1ns/1ps
`default_nettype none
module shbp_dpram (
    input wire logic ref_clk_i,
    input wire logic [5:0] a_addr_i,
    input wire logic a_we_i,
    input wire logic [7:0] a_wdata_i,
    output logic [7:0] a_rdata_o,
    input wire logic [5:0] b_addr_i,
    input wire logic b_we_i,
    input wire logic [7:0] b_wdata_i,
    output logic [7:0] b_rdata_o
);

    logic [7:0] mem [64];

    // ----------------------------------------------------------------
    // storage; the system write is last so it wins a same-byte clash
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (b_we_i) begin
            mem[b_addr_i] <= b_wdata_i;
        end
        if (a_we_i) begin
            mem[a_addr_i] <= a_wdata_i;
        end
    end

    // asynchronous read; callers register the result
    assign a_rdata_o = mem[a_addr_i];
    assign b_rdata_o = mem[b_addr_i];

endmodule
`default_nettype wire

//--- design/shbp_gpio.sv
// Purpose: general port with per-bit direction register
// Assumes: one writer per cycle selects data or direction
// Notes: a bit drives its pin only while its direction bit is 1
`timescale 1ns/1ps
`default_nettype none
`include "shbp_defs.svh"
module shbp_gpio #(
    parameter int W = 8
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic wr_data_i,
    input wire logic wr_dir_i,
    input wire logic [W-1:0] wdata_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe_o,
    output logic [W-1:0] dir_o,
    output logic [W-1:0] rd_o
);

    // ----------------------------------------------------------------
    // width check
    // ----------------------------------------------------------------
    if (W < 1 || W > 8) begin : g_bad_w
        $error("shbp_gpio: width must be 1 to 8");
    end

    logic [W-1:0] out_q, out_d, dir_q, dir_d;

    // latch and direction next values
    always_comb begin
        out_d = out_q;
        dir_d = dir_q;
        if (wr_data_i) begin
            out_d = wdata_i;
        end
        if (wr_dir_i) begin
            dir_d = wdata_i;
        end
    end

    // all bits come out of reset as inputs
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            out_q <= W'(`SHBP_OUT_RST);
            dir_q <= W'(`SHBP_DIR_RST);
        end else begin
            out_q <= out_d;
            dir_q <= dir_d;
        end
    end

    // readback: output bits show the latch, input bits the pin
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign rd_o[i] = dir_q[i] ? out_q[i] : pin_i[i];
    end

    assign pin_o = out_q;
    assign pin_oe_o = dir_q;
    assign dir_o = dir_q;

endmodule
`default_nettype wire

//--- design/shbp_pkg.sv
// Purpose: types shared by the slave host bus port files
// Assumes: nothing
// Notes: constants live in shbp_defs.svh
`default_nettype none
package shbp_pkg;

    // ----------------------------------------------------------------
    // bus carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [6:0] addr;
        logic [7:0] data;
    } shbp_hbus_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [12:0] addr;
        logic [7:0] wdata;
    } shbp_lbus_t;

    // ----------------------------------------------------------------
    // host access sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SHBP_ST_IDLE = 3'b001,
        SHBP_ST_READ = 3'b010,
        SHBP_ST_WRITE = 3'b100
    } shbp_host_st_t;

endpackage
`default_nettype wire

//--- design/shbp_port.sv
// Purpose: slave host bus port with its shared memory and ports
// Assumes: bus inputs synchronous to ref_clk_i
// Notes: data out and its enable lag the strobes by one cycle
//
// Behaviour
// - 8-bit system-side port, each bit individually input or output.
// - system-side port reachable only from the system bus, never locally.
// - reset turns every system-side port bit into an input.
// - 6-bit shared port read/written locally, system bus reads it only.
// - clear-to-send pin also works as an extra shared port bit.
// - system reads and writes accepted only while select is low.
// - read strobe with select drives the addressed contents onto data pins.
// - write strobe with select stores data pins at the addressed location.
// - seven system address lines decode a 128-byte space, 8-bit data.
// - local bus has 13 address lines, 8 data lines, 8192 bytes.
// - 4096-byte program ROM sits at local 1000 to 1FFF, vectors included.
// - each memory or register sits on one or both buses at own addresses.
// - one local interrupt source raised by system bus activity.
// - select high floats data pins and refuses all accesses.
// - any system access to the first mode/error location raises the interrupt.
// - system addresses 00 to 3F reach the 64-byte dual-port RAM.
`timescale 1ns/1ps
`default_nettype none
`include "shbp_defs.svh"
module shbp_port
    import shbp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire shbp_hbus_t hbus_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_o,
    output logic host_access_irq_o,
    input wire shbp_lbus_t lbus_i,
    output logic [7:0] loc_rdata_o,
    output logic [11:0] rom_addr_o,
    input wire logic [7:0] rom_data_i,
    input wire logic [7:0] system_side_port_i,
    output logic [7:0] system_side_port_o,
    output logic [7:0] system_side_port_oe_o,
    input wire logic [5:0] shared_port_i,
    output logic [5:0] shared_port_o,
    output logic [5:0] shared_port_oe_o,
    input wire logic cts_i,
    output logic cts_o,
    output logic cts_oe_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    shbp_host_st_t st_q, st_d;
    logic [7:0] hdata_q, hdata_d;
    logic hoe_q, hoe_d;
    logic irq_q, irq_d;
    logic [7:0] mode0_q, mode0_d;
    logic [7:0] err0_q, err0_d;
    logic [7:0] lrd_q, lrd_d;
    logic sys_start, sys_we, sys_re;
    logic [7:0] sys_rdata, loc_rdata;
    logic [7:0] dp_a_rdata, dp_b_rdata;
    logic loc_dp_hit, loc_rom_hit;
    logic [7:0] ssp_dir, ssp_rd;
    logic [6:0] shp_dir, shp_rd, shp_pin_i, shp_pin_o, shp_pin_oe;

    // ----------------------------------------------------------------
    // host access sequencer
    // ----------------------------------------------------------------
    // one access per strobe assertion; a held strobe is not repeated
    always_comb begin
        st_d = st_q;
        sys_start = 1'b0;
        case (st_q)
            SHBP_ST_IDLE: begin
                if (!hbus_i.cs_n && !hbus_i.rd_n) begin
                    st_d = SHBP_ST_READ;
                    sys_start = 1'b1;
                end else if (!hbus_i.cs_n && !hbus_i.wr_n) begin
                    st_d = SHBP_ST_WRITE;
                    sys_start = 1'b1;
                end
            end
            SHBP_ST_READ: begin
                if (hbus_i.cs_n || hbus_i.rd_n) begin
                    st_d = SHBP_ST_IDLE;
                end
            end
            SHBP_ST_WRITE: begin
                if (hbus_i.cs_n || hbus_i.wr_n) begin
                    st_d = SHBP_ST_IDLE;
                end
            end
            default: begin
                st_d = SHBP_ST_IDLE;
            end
        endcase
    end

    // read wins a strobe clash, the case the master must avoid
    assign sys_we = sys_start && (st_d == SHBP_ST_WRITE);
    assign sys_re = sys_start && (st_d == SHBP_ST_READ);

    // ----------------------------------------------------------------
    // system bus read decode
    // ----------------------------------------------------------------
    // unmapped system addresses read as zero
    always_comb begin
        sys_rdata = `SHBP_IDLE_DATA;
        if (!hbus_i.addr[6]) begin
            sys_rdata = dp_a_rdata;
        end else begin
            case (hbus_i.addr)
                `SHBP_SYS_SSP_DATA: sys_rdata = ssp_rd;
                `SHBP_SYS_SSP_DIR: sys_rdata = ssp_dir;
                `SHBP_SYS_SHP_IN: sys_rdata = {2'b00, shp_rd[5:0]};
                `SHBP_SYS_IPC0: sys_rdata = err0_q;
                default: sys_rdata = `SHBP_IDLE_DATA;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // local bus decode
    // ----------------------------------------------------------------
    assign loc_dp_hit = (lbus_i.addr >= `SHBP_LOC_DP_BASE) && (lbus_i.addr <= `SHBP_LOC_DP_LAST);
    assign loc_rom_hit = (lbus_i.addr >= `SHBP_LOC_ROM_BASE);
    assign rom_addr_o = lbus_i.addr[11:0];

    // no system-side port entry here: that port is host only
    always_comb begin
        loc_rdata = `SHBP_IDLE_DATA;
        if (loc_rom_hit) begin
            loc_rdata = rom_data_i;
        end else if (loc_dp_hit) begin
            loc_rdata = dp_b_rdata;
        end else begin
            case (lbus_i.addr)
                `SHBP_LOC_SHP_DATA: loc_rdata = {1'b0, shp_rd};
                `SHBP_LOC_SHP_DIR: loc_rdata = {1'b0, shp_dir};
                `SHBP_LOC_MODE0: loc_rdata = mode0_q;
                `SHBP_LOC_IPCE0: loc_rdata = err0_q;
                default: loc_rdata = `SHBP_IDLE_DATA;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output data, interrupt and mailbox next values
    // ----------------------------------------------------------------
    // data is refreshed while the read strobe stays low
    always_comb begin
        hoe_d = (st_d == SHBP_ST_READ);
        hdata_d = hoe_d ? sys_rdata : hdata_q;
        irq_d = sys_start && (hbus_i.addr == `SHBP_SYS_IPC0);
        mode0_d = mode0_q;
        if (sys_we && (hbus_i.addr == `SHBP_SYS_IPC0)) begin
            mode0_d = hbus_i.data;
        end
        // host read clears the error flags; a local write in the same cycle wins
        err0_d = err0_q;
        if (sys_re && (hbus_i.addr == `SHBP_SYS_IPC0)) begin
            err0_d = `SHBP_REG_RST;
        end
        if (lbus_i.wr && (lbus_i.addr == `SHBP_LOC_IPCE0)) begin
            err0_d = lbus_i.wdata;
        end
        lrd_d = lbus_i.rd ? loc_rdata : lrd_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st_q <= SHBP_ST_IDLE;
            hdata_q <= `SHBP_IDLE_DATA;
            hoe_q <= 1'b0;
            irq_q <= 1'b0;
            mode0_q <= `SHBP_REG_RST;
            err0_q <= `SHBP_REG_RST;
            lrd_q <= `SHBP_IDLE_DATA;
        end else begin
            st_q <= st_d;
            hdata_q <= hdata_d;
            hoe_q <= hoe_d;
            irq_q <= irq_d;
            mode0_q <= mode0_d;
            err0_q <= err0_d;
            lrd_q <= lrd_d;
        end
    end

    assign host_data_o = hdata_q;
    assign host_data_oe_o = hoe_q;
    assign host_access_irq_o = irq_q;
    assign loc_rdata_o = lrd_q;

    // ----------------------------------------------------------------
    // memories and ports
    // ----------------------------------------------------------------
    shbp_dpram u_dpram (
        .ref_clk_i(ref_clk_i),
        .a_addr_i(hbus_i.addr[5:0]),
        .a_we_i(sys_we && !hbus_i.addr[6]),
        .a_wdata_i(hbus_i.data),
        .a_rdata_o(dp_a_rdata),
        .b_addr_i(lbus_i.addr[5:0]),
        .b_we_i(lbus_i.wr && loc_dp_hit),
        .b_wdata_i(lbus_i.wdata),
        .b_rdata_o(dp_b_rdata)
    );

    // system-side port: written from the system bus only
    shbp_gpio #(.W(8)) u_ssp (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .wr_data_i(sys_we && (hbus_i.addr == `SHBP_SYS_SSP_DATA)),
        .wr_dir_i(sys_we && (hbus_i.addr == `SHBP_SYS_SSP_DIR)),
        .wdata_i(hbus_i.data),
        .pin_i(system_side_port_i),
        .pin_o(system_side_port_o),
        .pin_oe_o(system_side_port_oe_o),
        .dir_o(ssp_dir),
        .rd_o(ssp_rd)
    );

    // shared port with the clear-to-send pin as bit 6
    assign shp_pin_i = {cts_i, shared_port_i};
    shbp_gpio #(.W(7)) u_shp (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .wr_data_i(lbus_i.wr && (lbus_i.addr == `SHBP_LOC_SHP_DATA)),
        .wr_dir_i(lbus_i.wr && (lbus_i.addr == `SHBP_LOC_SHP_DIR)),
        .wdata_i(lbus_i.wdata[6:0]),
        .pin_i(shp_pin_i),
        .pin_o(shp_pin_o),
        .pin_oe_o(shp_pin_oe),
        .dir_o(shp_dir),
        .rd_o(shp_rd)
    );
    assign shared_port_o = shp_pin_o[5:0];
    assign shared_port_oe_o = shp_pin_oe[5:0];
    assign cts_o = shp_pin_o[6];
    assign cts_oe_o = shp_pin_oe[6];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_DIR_RESET: assert property (
        @(posedge ref_clk_i) $rose(rstn_i) |-> (system_side_port_oe_o == 8'h00))
        else $error("system-side port not all inputs after reset");

    AST_CS_FLOAT: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i) hbus_i.cs_n |=> !host_data_oe_o)
        else $error("data pins driven with select high");

    AST_READ_DATA: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        sys_re |=> host_data_oe_o && (host_data_o == $past(sys_rdata)))
        else $error("read did not return addressed contents");

    AST_SSP_WRITE: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        sys_we && (hbus_i.addr == `SHBP_SYS_SSP_DATA)
        |=> (system_side_port_o == $past(hbus_i.data)))
        else $error("host write to system-side port lost");

    AST_IRQ_CAUSE: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        sys_start && (hbus_i.addr == `SHBP_SYS_IPC0) |=> host_access_irq_o ##1 !host_access_irq_o)
        else $error("mode location access gave no single irq pulse");

    AST_IRQ_ONLY: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        host_access_irq_o |-> $past(sys_start) && ($past(hbus_i.addr) == `SHBP_SYS_IPC0))
        else $error("irq without host access");

    AST_SSP_LOCAL: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        lbus_i.wr && !sys_we |=> $stable(system_side_port_o) && $stable(system_side_port_oe_o))
        else $error("local bus changed system-side port");

    AST_SHP_SYS_READ: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        sys_re && (hbus_i.addr == `SHBP_SYS_SHP_IN)
        |=> (host_data_o[7:6] == 2'b00) && (host_data_o[5:0] == $past(shp_rd[5:0])))
        else $error("shared port system read wrong");

    AST_CTS_DIR: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        lbus_i.wr && (lbus_i.addr == `SHBP_LOC_SHP_DIR) |=> (cts_oe_o == $past(lbus_i.wdata[6])))
        else $error("cts direction not set by shared port write");

    AST_ROM_READ: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        lbus_i.rd && (lbus_i.addr >= `SHBP_LOC_ROM_BASE) |=> (loc_rdata_o == $past(rom_data_i)))
        else $error("rom read wrong");

endmodule
`default_nettype wire
